/* bench/ext_master_model.sv */
/*
  Model of the external parallel master that strobes the slave buffers.
  Assumes the bench asks for one access at a time, one cycle per request.
*/
`timescale 1ns/100ps
`default_nettype none
module ext_master_model (
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  input  wire logic       req_wr_i,   // Ask for one write strobe
  input  wire logic       req_rd_i,   // Ask for one read strobe
  input  wire logic [1:0] sel_i,      // Buffer to access
  output logic            ext_wr_o,
  output logic            ext_rd_o,
  output logic [1:0]      ext_addr_o
);
  ////////////////////////////////////////////////////////////////////////
  // One-cycle strobes; idle address flips so a stale index never looks valid
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ext_wr_o   <= 1'b0;
      ext_rd_o   <= 1'b0;
      ext_addr_o <= 2'h0;
    end else begin
      ext_wr_o   <= req_wr_i;
      ext_rd_o   <= req_rd_i;
      ext_addr_o <= (req_wr_i | req_rd_i) ? sel_i : ~ext_addr_o;
    end
  end
endmodule
`default_nettype wire

/* bench/test_parallel_port_pins.sv */
/*
  Self-checking bench for the pin enables and slave buffer status.
  Assumes the register offsets and field layout of the design package.
*/
`timescale 1ns/100ps
`default_nettype none
module test_parallel_port_pins;
  logic        mclk_i, rst_b_i, read_i, write_i, req_wr, req_rd;
  logic        waitrequest_o, ext_wr, ext_rd, irq_o, port_irq_o, err_o;
  logic        p15_cs, p14_cs, latch;
  logic [1:0]  sel, ext_addr;
  logic [3:0]  sw_in_read_i, sw_out_write_i;
  logic [4:0]  address_i;
  logic [15:0] pin_is_port_o;
  logic [31:0] writedata_i, readdata_o, seed, r;
  logic [31:0] rq[$];            // Expected read data, oldest first
  logic [31:0] eq[$], pq[$];     // Expected error and port interrupt pulses
  int          num_errors = 0;
  int          comparisons = 0;

  parallel_port_pins dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(4'hF),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .ext_wr_i(ext_wr),
    .ext_rd_i(ext_rd), .ext_addr_i(ext_addr), .sw_in_read_i(sw_in_read_i),
    .sw_out_write_i(sw_out_write_i), .pin_is_port_o(pin_is_port_o),
    .pin15_is_cs_o(p15_cs), .pin14_is_cs_o(p14_cs), .pin1_0_is_latch_o(latch),
    .port_irq_o(port_irq_o), .port_error_interrupt_o(err_o), .irq_o(irq_o));
  ext_master_model master (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .req_wr_i(req_wr),
    .req_rd_i(req_rd), .sel_i(sel), .ext_wr_o(ext_wr), .ext_rd_o(ext_rd),
    .ext_addr_o(ext_addr));

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Avalon request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk_i);
    write_i <= w;
    read_i <= !w;
    address_i <= a;
    writedata_i <= d;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (waitrequest_o !== 1'b0 && n < 20);
    if (waitrequest_o !== 1'b0) begin
      num_errors++;
      end_of_test();
    end
    write_i <= 1'b0;
    read_i <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  // External strobe and software buffer pulses, with expected interrupt pulses
  task automatic ev(input logic w, input logic rr, input logic [1:0] s,
                    input logic [3:0] ird, input logic [3:0] owr, input bit er, input bit pi);
    if (er) eq.push_back(32'h1);
    if (pi) pq.push_back(32'h1);
    @(posedge mclk_i);
    req_wr <= w;
    req_rd <= rr;
    sel <= s;
    sw_in_read_i <= ird;
    sw_out_write_i <= owr;
    @(posedge mclk_i);
    req_wr <= 1'b0;
    req_rd <= 1'b0;
    sw_in_read_i <= 4'h0;
    sw_out_write_i <= 4'h0;
    repeat (5) @(posedge mclk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Watcher: read data at the accepting edge, interrupt pulses as they come
  always @(posedge mclk_i) begin
    if (read_i === 1'b1 && waitrequest_o === 1'b0)
      chk(readdata_o, rq.size() ? rq.pop_front() : 32'hDEAD0000);
    if (err_o === 1'b1)
      chk(32'h1, eq.size() ? eq.pop_front() : 32'h0);
    if (port_irq_o === 1'b1)
      chk(32'h1, pq.size() ? pq.pop_front() : 32'h0);
  end

  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst_b_i, read_i, write_i, req_wr, req_rd} = '0;
    {sel, sw_in_read_i, sw_out_write_i, address_i, writedata_i} = '0;
    seed = 32'h8AFDA7A5;
    repeat (6) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    chk({waitrequest_o, irq_o, pin_is_port_o}, 32'h20000);
    rd(5'h04, 32'h0000008F);
    rd(5'h00, 32'h0);
    rd(5'h14, 32'h0);
    $display("reset values done");
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      r = seed;
      bus(1'b1, 5'h00, r);
      rd(5'h00, r & 32'h0000C7FF);
      chk(pin_is_port_o, r[15:0] & 16'hC7FF);
    end
    bus(1'b1, 5'h00, 32'hFFFFFFFF);
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, 5'h08, {24'h0, 1'b0, c[2], c[1:0], 4'h0});
      repeat (2) @(posedge mclk_i);
      chk({p15_cs, p14_cs, latch}, {c[1:0] != 2'h0, c[1], c[2]});
    end
    $display("pin enables done");
    bus(1'b1, 5'h10, 32'h2);
    bus(1'b1, 5'h08, 32'h09);
    for (int b = 0; b < 3; b++) ev(1, 0, b[1:0], 4'h0, 4'h0, 0, 0);
    rd(5'h04, 32'h0000078F);
    ev(1, 0, 2'h3, 4'h0, 4'h0, 0, 1);
    rd(5'h04, 32'h00008F8F);
    ev(1, 0, 2'h0, 4'h0, 4'h0, 1, 0);
    rd(5'h04, 32'h0000CF8F);
    chk(irq_o, 1'b1);
    rd(5'h0C, 32'h3);
    bus(1'b1, 5'h0C, 32'h3);
    rd(5'h0C, 32'h0);
    chk(irq_o, 1'b0);
    ev(0, 0, 2'h0, 4'h5, 4'h0, 0, 0);
    rd(5'h04, 32'h00004A8F);
    bus(1'b1, 5'h04, 32'h0);
    rd(5'h04, 32'h00000A8F);
    $display("input buffers done");
    ev(0, 0, 2'h0, 4'h0, 4'hE, 0, 0);
    rd(5'h04, 32'h00000A01);
    bus(1'b1, 5'h10, 32'h0);
    ev(0, 1, 2'h0, 4'h0, 4'h0, 1, 0);
    rd(5'h04, 32'h00000A41);
    rd(5'h0C, 32'h2);
    chk(irq_o, 1'b0);
    $display("output buffers done");
    bus(1'b1, 5'h08, 32'h02);
    ev(1, 0, 2'h1, 4'h0, 4'h0, 0, 0);
    rd(5'h04, 32'h00000A41);
    bus(1'b1, 5'h08, 32'h01);
    ev(1, 0, 2'h1, 4'h0, 4'h0, 1, 0);
    rd(5'h04, 32'h00004A41);
    bus(1'b1, 5'h08, 32'h00);
    ev(1, 0, 2'h3, 4'h0, 4'h0, 0, 0);
    rd(5'h04, 32'h00004B41);
    repeat (4) @(posedge mclk_i);
    chk(eq.size() + pq.size() + rq.size(), 32'h0);
    $display("modes done");
    end_of_test();
  end
endmodule
`default_nettype wire

/* include/pport_buf_if.sv */
/*
  Interface carrying buffer events from the top into the status tracker.
  Assumes both ends share mclk_i.
*/
`timescale 1ns/100ps
`default_nettype none
interface pport_buf_if;
  logic       slave_mode;     // Slave modes active
  logic [1:0] ext_wr_sel;     // Buffer index of external write
  logic       ext_wr;         // External master write strobe
  logic [1:0] ext_rd_sel;     // Buffer index of external read
  logic       ext_rd;         // External master read strobe
  logic [3:0] sw_in_read;     // Software reads of input buffers
  logic [3:0] sw_out_write;   // Software writes of output buffers
  logic       clr_overflow;   // Software clear of overflow
  logic       clr_underflow;  // Software clear of underflow
  logic [15:0] status;        // Assembled status word
  logic       overflow_evt;   // One-cycle overflow event
  logic       underflow_evt;  // One-cycle underflow event
  modport tracker (input slave_mode, ext_wr_sel, ext_wr, ext_rd_sel, ext_rd,
                   sw_in_read, sw_out_write, clr_overflow, clr_underflow,
                   output status, overflow_evt, underflow_evt);
  modport owner   (output slave_mode, ext_wr_sel, ext_wr, ext_rd_sel, ext_rd,
                   sw_in_read, sw_out_write, clr_overflow, clr_underflow,
                   input status, overflow_evt, underflow_evt);
endinterface
`default_nettype wire

/* include/pport_pkg.sv */
/*
  Package for the parallel-port pin-enable and slave buffer status block:
  register offsets, field positions, reset values and mode encodings.
  Assumes a 32-bit Avalon-MM slave with word-aligned registers.
*/
`default_nettype none
package pport_pkg;
  // Register byte offsets (chosen, word aligned)
  localparam logic [3:0]  PIN_FUNCTION_ENABLE_OFS = 4'h0;
  localparam logic [3:0]  SLAVE_BUFFER_STATUS_OFS = 4'h4;
  localparam logic [3:0]  PORT_CONTROL_OFS        = 4'h8;
  localparam logic [3:0]  IRQ_STATUS_OFS          = 4'hC;
  localparam logic [3:0]  IRQ_MASK_OFS            = 4'h0;  // Upper page, see IRQ_MASK_ADDR
  localparam logic [4:0]  IRQ_MASK_ADDR           = 5'h10;
  // Implemented pin-enable bits: 15-14, 10-2, 1-0
  localparam logic [15:0] PIN_ENABLE_IMPL         = 16'hC7FF;
  localparam logic [15:0] PIN_ENABLE_RESET        = 16'h0000;
  // Status layout
  localparam int          IN_ALL_FULL_BIT         = 15;
  localparam int          IN_OVERFLOW_BIT         = 14;
  localparam int          IN_FULL_LSB             = 8;
  localparam int          OUT_ALL_EMPTY_BIT       = 7;
  localparam int          OUT_UNDERFLOW_BIT       = 6;
  localparam int          OUT_EMPTY_LSB           = 0;
  localparam logic [15:0] STATUS_RESET            = 16'h008F;
  // Port control layout
  localparam int          PORT_MODE_LSB           = 0;   // 2 bits
  localparam int          IRQ_MODE_LSB            = 2;   // 2 bits
  localparam int          CS_FUNC_LSB             = 4;   // 2 bits
  localparam int          ADDR_MUX_LSB            = 6;   // 2 bits
  localparam logic [1:0]  MODE_LEGACY_SLAVE       = 2'h0;
  localparam logic [1:0]  MODE_ENHANCED_SLAVE     = 2'h1;
  localparam logic [1:0]  IRQ_MODE_BUFFER3        = 2'h2;
  localparam logic [1:0]  IRQ_MODE_EVERY_CYCLE    = 2'h1;
  localparam logic [1:0]  CS_FUNC_ADDRESS         = 2'h0;
  localparam logic [1:0]  CS_FUNC_CS2_ONLY        = 2'h1;
  localparam logic [1:0]  ADDR_MUX_NONE           = 2'h0;
  localparam int          NUM_BUFFERS             = 4;
endpackage
`default_nettype wire

/* logic/buffer_status.sv */
/*
  Slave buffer status tracker: per-buffer full/empty flags, summaries,
  sticky overflow/underflow. Assumes strobes are one-cycle pulses.
*/
`timescale 1ns/100ps
`default_nettype none
module buffer_status (
  input  wire logic     mclk_i,
  input  wire logic     rst_b_i,
  pport_buf_if.tracker  bus
);
  logic [3:0] in_full_reg,  in_full_next;   // Input buffer holds data
  logic [3:0] out_empty_reg, out_empty_next; // Output buffer empty
  logic       ovf_reg, ovf_next;             // Sticky overflow
  logic       unf_reg, unf_next;             // Sticky underflow
  logic       ovf_evt, unf_evt;              // Events this cycle

  ////////////////////////////////////////////////////////////////////////////
  // Next-state: external strobes fill/drain, software drains/fills
  always_comb begin
    in_full_next   = in_full_reg;
    out_empty_next = out_empty_reg;
    ovf_evt        = 1'b0;
    unf_evt        = 1'b0;
    // Software read empties an input buffer
    in_full_next   = in_full_next & ~bus.sw_in_read;        // R8
    // Software write fills an output buffer
    out_empty_next = out_empty_next & ~bus.sw_out_write;    // R11
    if (bus.slave_mode && bus.ext_wr) begin                 // R5
      if (in_full_reg[bus.ext_wr_sel]) begin
        ovf_evt = 1'b1;                                     // R7
      end else begin
        in_full_next[bus.ext_wr_sel] = 1'b1;                // R8
      end
    end
    if (bus.slave_mode && bus.ext_rd) begin
      if (out_empty_reg[bus.ext_rd_sel]) begin
        unf_evt = 1'b1;                                     // R10
      end else begin
        out_empty_next[bus.ext_rd_sel] = 1'b1;              // R11
      end
    end
    // Set wins over a clear in the same cycle
    ovf_next = ovf_evt | (ovf_reg & ~bus.clr_overflow);     // R7
    unf_next = unf_evt | (unf_reg & ~bus.clr_underflow);    // R10
  end

  // Registers only
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      in_full_reg   <= pport_pkg::STATUS_RESET[pport_pkg::IN_FULL_LSB +: 4];   // R17
      out_empty_reg <= pport_pkg::STATUS_RESET[pport_pkg::OUT_EMPTY_LSB +: 4]; // R17
      ovf_reg       <= 1'b0;
      unf_reg       <= 1'b0;
    end else begin
      in_full_reg   <= in_full_next;
      out_empty_reg <= out_empty_next;
      ovf_reg       <= ovf_next;
      unf_reg       <= unf_next;
    end
  end

  // Status word; unimplemented bits tie to zero
  always_comb begin
    bus.status = 16'h0000;                                  // R13
    bus.status[pport_pkg::IN_ALL_FULL_BIT]   = &in_full_reg;    // R6
    bus.status[pport_pkg::IN_OVERFLOW_BIT]   = ovf_reg;
    bus.status[pport_pkg::IN_FULL_LSB +: 4]  = in_full_reg;
    bus.status[pport_pkg::OUT_ALL_EMPTY_BIT] = &out_empty_reg;  // R9
    bus.status[pport_pkg::OUT_UNDERFLOW_BIT] = unf_reg;
    bus.status[pport_pkg::OUT_EMPTY_LSB +: 4] = out_empty_reg;
  end
  assign bus.overflow_evt  = ovf_evt;
  assign bus.underflow_evt = unf_evt;

  ovf_set_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R7
    bus.slave_mode && bus.ext_wr && in_full_reg[bus.ext_wr_sel] |=> ovf_reg)
    else $error("overflow flag not set on write to full buffer");
  unf_set_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R10
    bus.slave_mode && bus.ext_rd && out_empty_reg[bus.ext_rd_sel] |=> unf_reg)
    else $error("underflow flag not set on read of empty buffer");
  in_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R8
    bus.sw_in_read[0] && !(bus.ext_wr && bus.ext_wr_sel == 2'h0) |=> !in_full_reg[0])
    else $error("input full bit not cleared by software read");
  out_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R11
    bus.sw_out_write[0] && !(bus.ext_rd && bus.ext_rd_sel == 2'h0) |=> !out_empty_reg[0])
    else $error("output empty bit not cleared by software write");
  ovf_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R7
    ovf_reg && !bus.clr_overflow |=> ovf_reg)
    else $error("overflow flag dropped without clear");
  mode_gate_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R5
    !bus.slave_mode && !ovf_reg && !bus.clr_overflow |=> !ovf_reg)
    else $error("overflow raised outside slave mode");
endmodule
`default_nettype wire

/* logic/parallel_port_pins.sv */
/*
  Parallel port pin-function enables and slave buffer status, Avalon-MM slave.
  Assumes the slave strobes arrive synchronous to mclk_i as one-cycle pulses.
*/
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
// Notes on behaviour
// R1: Top enables route pins 15-14 to port
// R2: Enables 10-2 make address pins port lines
// R3: Low enables give address or latch strobes
// R4: Enable bits 13-11 and upper half zero
// R5: Buffer status counts only in slave modes; software buffer reads and writes update it in any mode
// R6: Input summary set when all buffers full
// R7: Write to full input sets sticky overflow
// R8: Input full set on write, cleared on read
// R9: Output summary set when all buffers empty
// R10: Read of empty output sets sticky underflow
// R11: Output empty cleared by software write
// R12: Overflow or underflow raises error interrupt
// R13: Unimplemented status bits read zero
// R14: Error interrupt ignores interrupt request mode
// R15: Mode 10 interrupts on buffer 3 access
// R16: Mode 01 enhanced slave, 00 legacy slave
// R17: Status resets to 0x8F
`timescale 1ns/100ps
`default_nettype none
module parallel_port_pins (
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  // Avalon-MM slave
  input  wire logic [4:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  input  wire logic [3:0]  byteenable_i,
  output logic [31:0]      readdata_o,
  output logic             waitrequest_o,
  // External master slave-mode strobes
  input  wire logic        ext_wr_i,
  input  wire logic        ext_rd_i,
  input  wire logic [1:0]  ext_addr_i,
  // Software buffer accesses from the data path
  input  wire logic [3:0]  sw_in_read_i,
  input  wire logic [3:0]  sw_out_write_i,
  // Pin function selects, 1 = port function, 0 = general I/O
  output logic [15:0]      pin_is_port_o,
  output logic             pin15_is_cs_o,
  output logic             pin14_is_cs_o,
  output logic             pin1_0_is_latch_o,
  output logic             port_irq_o,
  output logic             port_error_interrupt_o,
  output logic             irq_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Decode helper
  function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
    hit = (a == ofs);
  endfunction

  pport_buf_if bif ();                 // Link to status tracker

  logic [15:0] pin_enable_reg, pin_enable_next;  // Pin-function enables
  logic [7:0]  ctrl_reg, ctrl_next;              // Mode/irq/cs/mux fields
  logic [1:0]  irq_stat_reg, irq_stat_next;      // Sticky [0]=port,[1]=error
  logic [1:0]  irq_mask_reg, irq_mask_next;      // Mask, same layout
  logic [31:0] rdata_reg, rdata_next;            // Read data
  logic        wait_reg, wait_next;              // Waitrequest
  logic [15:0] pins_reg, pins_next;
  logic        cs15_reg, cs15_next, cs14_reg, cs14_next, latch_reg, latch_next;
  logic        pirq_reg, pirq_next, perr_reg, perr_next, irq_reg, irq_next;
  logic        port_evt;                         // Ordinary port event
  logic        req, wr_take;                     // Bus request / accepted write
  logic [1:0]  mode, irq_mode, cs_func, amux;

  assign mode     = ctrl_reg[pport_pkg::PORT_MODE_LSB +: 2];
  assign irq_mode = ctrl_reg[pport_pkg::IRQ_MODE_LSB +: 2];
  assign cs_func  = ctrl_reg[pport_pkg::CS_FUNC_LSB +: 2];
  assign amux     = ctrl_reg[pport_pkg::ADDR_MUX_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // Tracker hookup; enhanced slave decodes two address lines, legacy none
  always_comb begin
    bif.slave_mode = (mode == pport_pkg::MODE_LEGACY_SLAVE) ||
                     (mode == pport_pkg::MODE_ENHANCED_SLAVE);             // R16
    bif.ext_wr_sel = (mode == pport_pkg::MODE_ENHANCED_SLAVE) ? ext_addr_i : 2'h0; // R16
    bif.ext_rd_sel = (mode == pport_pkg::MODE_ENHANCED_SLAVE) ? ext_addr_i : 2'h0;
    bif.ext_wr     = ext_wr_i;
    bif.ext_rd     = ext_rd_i;
    bif.sw_in_read   = sw_in_read_i;
    bif.sw_out_write = sw_out_write_i;
    bif.clr_overflow  = wr_take && hit(address_i, 5'(pport_pkg::SLAVE_BUFFER_STATUS_OFS))
                        && writedata_i[pport_pkg::IN_OVERFLOW_BIT] == 1'b0
                        && byteenable_i[1];
    bif.clr_underflow = wr_take && hit(address_i, 5'(pport_pkg::SLAVE_BUFFER_STATUS_OFS))
                        && writedata_i[pport_pkg::OUT_UNDERFLOW_BIT] == 1'b0
                        && byteenable_i[0];
  end

  buffer_status u_status (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .bus     (bif.tracker)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle, answer on the second edge of a request
  assign req     = read_i | write_i;
  assign wr_take = write_i && !wait_reg;

  // Port interrupt event per mode
  always_comb begin
    port_evt = 1'b0;
    if (bif.slave_mode) begin
      if (irq_mode == pport_pkg::IRQ_MODE_BUFFER3) begin                    // R15
        port_evt = (ext_wr_i && bif.ext_wr_sel == 2'h3) ||
                   (ext_rd_i && bif.ext_rd_sel == 2'h3);
      end else if (irq_mode == pport_pkg::IRQ_MODE_EVERY_CYCLE) begin
        port_evt = ext_wr_i | ext_rd_i;
      end else begin
        port_evt = 1'b0;                                                   // No port irq
      end
    end
  end

  // Register next values
  always_comb begin
    pin_enable_next = pin_enable_reg;
    ctrl_next       = ctrl_reg;
    irq_mask_next   = irq_mask_reg;
    irq_stat_next   = irq_stat_reg;
    rdata_next      = rdata_reg;
    wait_next       = 1'b1;
    // Answer: release wait one cycle after a request appears
    if (req && wait_reg) begin
      wait_next = 1'b0;
    end
    if (read_i && wait_reg) begin
      case (address_i)
        5'(pport_pkg::PIN_FUNCTION_ENABLE_OFS): rdata_next = {16'h0000, pin_enable_reg}; // R4
        5'(pport_pkg::SLAVE_BUFFER_STATUS_OFS): rdata_next = {16'h0000, bif.status};     // R13
        5'(pport_pkg::PORT_CONTROL_OFS):        rdata_next = {24'h000000, ctrl_reg};
        5'(pport_pkg::IRQ_STATUS_OFS):          rdata_next = {30'h0, irq_stat_reg};
        pport_pkg::IRQ_MASK_ADDR:               rdata_next = {30'h0, irq_mask_reg};
        default:                                rdata_next = 32'h0000_0000;  // Unmapped
      endcase
    end
    if (wr_take) begin
      if (hit(address_i, 5'(pport_pkg::PIN_FUNCTION_ENABLE_OFS))) begin
        if (byteenable_i[0]) begin
          pin_enable_next[7:0] = writedata_i[7:0] & pport_pkg::PIN_ENABLE_IMPL[7:0];   // R4
        end
        if (byteenable_i[1]) begin
          pin_enable_next[15:8] = writedata_i[15:8] & pport_pkg::PIN_ENABLE_IMPL[15:8]; // R4
        end
      end
      if (hit(address_i, 5'(pport_pkg::PORT_CONTROL_OFS)) && byteenable_i[0]) begin
        ctrl_next = writedata_i[7:0];
      end
      if (hit(address_i, pport_pkg::IRQ_MASK_ADDR) && byteenable_i[0]) begin
        irq_mask_next = writedata_i[1:0];
      end
      if (hit(address_i, 5'(pport_pkg::IRQ_STATUS_OFS)) && byteenable_i[0]) begin
        irq_stat_next = irq_stat_next & ~writedata_i[1:0];   // Write one to clear
      end
    end
    // Events set after clears so a set wins
    if (port_evt) irq_stat_next[0] = 1'b1;
    if (bif.overflow_evt || bif.underflow_evt) irq_stat_next[1] = 1'b1;   // R12 R14
  end

  // Pin routing
  always_comb begin
    pins_next  = pin_enable_reg;                                           // R2
    cs15_next  = pin_enable_reg[15] && (cs_func != pport_pkg::CS_FUNC_ADDRESS);  // R1
    cs14_next  = pin_enable_reg[14] && (cs_func != pport_pkg::CS_FUNC_ADDRESS)
                 && (cs_func != pport_pkg::CS_FUNC_CS2_ONLY);                    // R1
    latch_next = (pin_enable_reg[1:0] != 2'h0) && (amux != pport_pkg::ADDR_MUX_NONE); // R3
    pirq_next  = port_evt;
    perr_next  = bif.overflow_evt | bif.underflow_evt;                     // R12 R14
    irq_next   = |(irq_stat_next & irq_mask_next);
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_enable_reg <= pport_pkg::PIN_ENABLE_RESET;
      ctrl_reg       <= 8'h00;
      irq_stat_reg   <= 2'h0;
      irq_mask_reg   <= 2'h0;
      rdata_reg      <= 32'h0000_0000;
      wait_reg       <= 1'b1;
      pins_reg       <= 16'h0000;
      cs15_reg       <= 1'b0;
      cs14_reg       <= 1'b0;
      latch_reg      <= 1'b0;
      pirq_reg       <= 1'b0;
      perr_reg       <= 1'b0;
      irq_reg        <= 1'b0;
    end else begin
      pin_enable_reg <= pin_enable_next;
      ctrl_reg       <= ctrl_next;
      irq_stat_reg   <= irq_stat_next;
      irq_mask_reg   <= irq_mask_next;
      rdata_reg      <= rdata_next;
      wait_reg       <= wait_next;
      pins_reg       <= pins_next;
      cs15_reg       <= cs15_next;
      cs14_reg       <= cs14_next;
      latch_reg      <= latch_next;
      pirq_reg       <= pirq_next;
      perr_reg       <= perr_next;
      irq_reg        <= irq_next;
    end
  end

  assign readdata_o             = rdata_reg;
  assign waitrequest_o          = wait_reg;
  assign pin_is_port_o          = pins_reg;
  assign pin15_is_cs_o          = cs15_reg;
  assign pin14_is_cs_o          = cs14_reg;
  assign pin1_0_is_latch_o      = latch_reg;
  assign port_irq_o             = pirq_reg;
  assign port_error_interrupt_o = perr_reg;
  assign irq_o                  = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  unimpl_pins_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R4
    pin_is_port_o[13:11] == 3'h0)
    else $error("unimplemented pin enable bits set");
  pin_follow_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R2
    1'b1 |=> pin_is_port_o[10:2] == $past(pin_enable_reg[10:2]))
    else $error("address pin routing does not follow enables");
  err_irq_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R12
    bif.overflow_evt || bif.underflow_evt |=> port_error_interrupt_o)
    else $error("error interrupt missing");
  err_any_mode_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R14
    bif.overflow_evt && irq_mode == 2'h0 |=> port_error_interrupt_o)
    else $error("error interrupt gated by request mode");
  buf3_irq_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R15
    bif.slave_mode && irq_mode == 2'h2 && ext_wr_i && bif.ext_wr_sel == 2'h3 |=> port_irq_o)
    else $error("buffer 3 interrupt missing");
  cs_route_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R1
    !pin_enable_reg[15] |=> !pin15_is_cs_o)
    else $error("chip select routed with enable clear");
  latch_route_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R3
    amux == 2'h0 |=> !pin1_0_is_latch_o)
    else $error("latch strobes without multiplexing");
  stat_zero_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R13
    bif.status[13:12] == 2'h0 && bif.status[5:4] == 2'h0)
    else $error("unimplemented status bits nonzero");
  legacy_sel_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R16
    mode == 2'h0 |-> bif.ext_wr_sel == 2'h0)
    else $error("legacy slave uses address lines");
  bus_wait_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    req && wait_reg |=> !waitrequest_o)
    else $error("bus answer late");
  full_all_c: cover property (@(posedge mclk_i) bif.status[15]);
  ovf_c: cover property (@(posedge mclk_i) bif.overflow_evt);
  unf_c: cover property (@(posedge mclk_i) bif.underflow_evt);
  irq_c: cover property (@(posedge mclk_i) irq_o);
endmodule
`default_nettype wire
